//--- uevr_pkg.sv
package uevr_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] CTS_LOW_EVENT_OFS   = 12'h100;
	localparam logic [11:0] CTS_HIGH_EVENT_OFS  = 12'h104;
	localparam logic [11:0] RX_READY_EVENT_OFS  = 12'h108;
	localparam logic [11:0] TX_SENT_EVENT_OFS   = 12'h11c;
	localparam logic [11:0] ERROR_EVENT_OFS     = 12'h124;
	localparam logic [11:0] RX_TIMEOUT_EVENT_OFS = 12'h144;
	localparam logic [11:0] SHORTCUTS_OFS       = 12'h200;
	localparam logic [11:0] IRQ_ENABLE_SET_OFS  = 12'h304;
	localparam logic [11:0] IRQ_ENABLE_CLR_OFS  = 12'h308;
	localparam logic [11:0] EVENT_STATUS_OFS    = 12'h400;

	// ----------------------------------------------------------------
	// Event numbering, shared by flags, status and enable layouts
	// ----------------------------------------------------------------
	localparam int          NUM_EVENTS    = 6;
	localparam int          EV_CTS_LOW    = 0;
	localparam int          EV_CTS_HIGH   = 1;
	localparam int          EV_RX_READY   = 2;
	localparam int          EV_TX_SENT    = 3;
	localparam int          EV_ERROR      = 4;
	localparam int          EV_RX_TIMEOUT = 5;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int          EVENT_FLAG_BIT    = 0;
	localparam int          SC_START_RX_BIT   = 0;
	localparam int          SC_STOP_RX_BIT    = 1;
	localparam logic [5:0]  EVENT_FLAGS_RST   = 6'h00;
	localparam logic [1:0]  SHORTCUTS_RST     = 2'h0;
	localparam logic [5:0]  IRQ_ENABLE_RST    = 6'h00;
	localparam logic        CTS_LINE_RST      = 1'h1;
	localparam logic [31:0] READ_ZERO         = 32'h00000000;

endpackage : uevr_pkg

//--- uevr_flag_cell.sv
`timescale 1ns/100ps
`default_nettype none

module uevr_flag_cell (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic hw_set,
	input  wire logic sw_write,
	input  wire logic sw_value,
	input  wire logic sw_clear,
	output logic      flag
);

	// ----------------------------------------------------------------
	// Sticky event flag
	// ----------------------------------------------------------------
	logic flag_r;
	logic flag_nxt;

	// Hardware set beats any software write or clear
	assign flag_nxt = hw_set   ? 1'h1 :
	                  sw_write ? sw_value :
	                  sw_clear ? 1'h0 : flag_r;

	// Flag storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= 1'h0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	assign flag = flag_r;

endmodule : uevr_flag_cell

`default_nettype wire

//--- uevr_regs.sv
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none

// Function
// R1: Transmit-sent flag, bit 0 at 0x11C
// R2: Error-detected flag, bit 0 at 0x124
// R3: Receiver-timeout flag, bit 0 at 0x144
// R4: Event flags read-write, reset to zero
// R5: Shortcut register at 0x200, two bits
// R6: Bit 0: CTS activation starts receiver
// R7: Bit 1: CTS deactivation stops receiver
// R8: Six-bit interrupt enable set at 0x304
// R9: Writing one enables, zero leaves unchanged
// R10: Read returns current enable state
// R11: CTS low activates, CTS high deactivates
// R12: Writing one at 0x308 disables interrupt
// R13: Interrupt while enabled flag is set
// R14: Software zeroes flag before awaiting event
module uevr_regs (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cts_n,
	input  wire logic        transmit_sent,
	input  wire logic        receive_ready,
	input  wire logic        error_detected,
	input  wire logic        receiver_timeout,
	output logic             start_receive_task,
	output logic             stop_receive_task,
	output logic             irq
);

	// ----------------------------------------------------------------
	// Address decode helper
	// ----------------------------------------------------------------
	function automatic logic addr_hit(
		input logic [11:0] addr,
		input logic [11:0] ofs
	);
		addr_hit = (addr[11:2] == ofs[11:2]);
	endfunction : addr_hit

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [5:0]  event_flags;
	logic [5:0]  event_set;
	logic [5:0]  event_wr;
	logic [5:0]  status_clr;
	logic [1:0]  shortcuts_r;
	logic [1:0]  shortcuts_nxt;
	logic [5:0]  irq_enable_r;
	logic [5:0]  irq_enable_nxt;
	logic        cts_n_r;
	logic        start_rx_r;
	logic        stop_rx_r;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pslverr_r;
	logic        setup_phase;
	logic        access_phase;
	logic        wr_access;
	logic        sel_cts_low;
	logic        sel_cts_high;
	logic        sel_rx_ready;
	logic        sel_tx_sent;
	logic        sel_error;
	logic        sel_rx_timeout;
	logic        sel_shortcuts;
	logic        sel_en_set;
	logic        sel_en_clr;
	logic        sel_status;
	logic        sel_any;
	logic        wr_shortcuts;
	logic        wr_en_set;
	logic        wr_en_clr;
	logic        wr_status;
	logic        cts_fell;
	logic        cts_rose;
	logic [5:0]  event_sel;
	logic [31:0] flag_word;

	// ----------------------------------------------------------------
	// Bus phases
	// ----------------------------------------------------------------

	// Setup and access phase detection
	assign setup_phase  = psel & ~penable;
	assign access_phase = psel & penable;
	assign wr_access    = access_phase & pwrite;

	// ----------------------------------------------------------------
	// Register select decode
	// ----------------------------------------------------------------

	// One select per mapped word
	assign sel_cts_low    = addr_hit(paddr, uevr_pkg::CTS_LOW_EVENT_OFS);
	assign sel_cts_high   = addr_hit(paddr, uevr_pkg::CTS_HIGH_EVENT_OFS);
	assign sel_rx_ready   = addr_hit(paddr, uevr_pkg::RX_READY_EVENT_OFS);
	assign sel_tx_sent    = addr_hit(paddr, uevr_pkg::TX_SENT_EVENT_OFS); // R1
	assign sel_error      = addr_hit(paddr, uevr_pkg::ERROR_EVENT_OFS); // R2
	assign sel_rx_timeout = addr_hit(paddr,
	                                 uevr_pkg::RX_TIMEOUT_EVENT_OFS); // R3
	assign sel_shortcuts  = addr_hit(paddr, uevr_pkg::SHORTCUTS_OFS); // R5
	assign sel_en_set     = addr_hit(paddr, uevr_pkg::IRQ_ENABLE_SET_OFS); // R8
	assign sel_en_clr     = addr_hit(paddr, uevr_pkg::IRQ_ENABLE_CLR_OFS); // R12
	assign sel_status     = addr_hit(paddr, uevr_pkg::EVENT_STATUS_OFS);

	// Event registers gathered in event order
	assign event_sel[uevr_pkg::EV_CTS_LOW]    = sel_cts_low;
	assign event_sel[uevr_pkg::EV_CTS_HIGH]   = sel_cts_high;
	assign event_sel[uevr_pkg::EV_RX_READY]   = sel_rx_ready;
	assign event_sel[uevr_pkg::EV_TX_SENT]    = sel_tx_sent;
	assign event_sel[uevr_pkg::EV_ERROR]      = sel_error;
	assign event_sel[uevr_pkg::EV_RX_TIMEOUT] = sel_rx_timeout;

	// Any mapped word
	assign sel_any = (|event_sel) | sel_shortcuts | sel_en_set |
	                 sel_en_clr | sel_status;

	// Write strobes, taken at the access edge only
	assign wr_shortcuts = wr_access & sel_shortcuts;
	assign wr_en_set    = wr_access & sel_en_set;
	assign wr_en_clr    = wr_access & sel_en_clr;
	assign wr_status    = wr_access & sel_status;

	// ----------------------------------------------------------------
	// Clear-to-send edge detection
	// ----------------------------------------------------------------

	// Previous level of the line, idle high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cts_n_r <= uevr_pkg::CTS_LINE_RST;
		end else begin
			cts_n_r <= cts_n;
		end
	end

	// Falling edge activates, rising edge deactivates
	assign cts_fell = cts_n_r & ~cts_n; // R11
	assign cts_rose = ~cts_n_r & cts_n; // R11

	// ----------------------------------------------------------------
	// Event sources
	// ----------------------------------------------------------------

	// Hardware set pulses in event order
	assign event_set[uevr_pkg::EV_CTS_LOW]    = cts_fell; // R11
	assign event_set[uevr_pkg::EV_CTS_HIGH]   = cts_rose; // R11
	assign event_set[uevr_pkg::EV_RX_READY]   = receive_ready;
	assign event_set[uevr_pkg::EV_TX_SENT]    = transmit_sent; // R1
	assign event_set[uevr_pkg::EV_ERROR]      = error_detected; // R2
	assign event_set[uevr_pkg::EV_RX_TIMEOUT] = receiver_timeout; // R3

	// ----------------------------------------------------------------
	// Event flags
	// ----------------------------------------------------------------

	// Direct writes to each event register, and status clears
	assign event_wr   = {uevr_pkg::NUM_EVENTS{wr_access}} & event_sel; // R4
	assign status_clr = {uevr_pkg::NUM_EVENTS{wr_status}} & pwdata[5:0];

	// One sticky cell per event
	genvar gi;
	generate
		for (gi = 0; gi < uevr_pkg::NUM_EVENTS; gi = gi + 1) begin : g_flag
			uevr_flag_cell u_flag (
				.pclk     (pclk),
				.presetn  (presetn),
				.hw_set   (event_set[gi]),
				.sw_write (event_wr[gi]), // R4
				.sw_value (pwdata[uevr_pkg::EVENT_FLAG_BIT]),
				.sw_clear (status_clr[gi]),
				.flag     (event_flags[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Shortcut register
	// ----------------------------------------------------------------

	// Two read-write enable bits
	assign shortcuts_nxt = wr_shortcuts ? pwdata[1:0] : shortcuts_r; // R5

	// Shortcut storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shortcuts_r <= uevr_pkg::SHORTCUTS_RST; // R5
		end else begin
			shortcuts_r <= shortcuts_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Receiver task strobes
	// ----------------------------------------------------------------

	// One-cycle task pulses following the edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_rx_r <= 1'h0;
			stop_rx_r  <= 1'h0;
		end else begin
			start_rx_r <= cts_fell &
			              shortcuts_r[uevr_pkg::SC_START_RX_BIT]; // R6
			stop_rx_r  <= cts_rose &
			              shortcuts_r[uevr_pkg::SC_STOP_RX_BIT]; // R7
		end
	end

	assign start_receive_task = start_rx_r;
	assign stop_receive_task  = stop_rx_r;

	// ----------------------------------------------------------------
	// Interrupt enables
	// ----------------------------------------------------------------

	// Set by ones at set word, cleared by ones at clear word
	assign irq_enable_nxt = wr_en_set ? (irq_enable_r | pwdata[5:0]) : // R9
	                        wr_en_clr ? (irq_enable_r & ~pwdata[5:0]) : // R12
	                        irq_enable_r;

	// Enable storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_r <= uevr_pkg::IRQ_ENABLE_RST; // R8
		end else begin
			irq_enable_r <= irq_enable_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------

	// Level request while an enabled flag stands
	assign irq = |(event_flags & irq_enable_r); // R13

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------

	// Single flag of the addressed event register
	assign flag_word = {31'h00000000, |(event_sel & event_flags)};

	// Read mux, unmapped words read zero
	always_comb begin
		prdata_nxt = uevr_pkg::READ_ZERO;
		if (|event_sel) begin
			prdata_nxt = flag_word; // R4
		end else if (sel_shortcuts) begin
			prdata_nxt = {30'h00000000, shortcuts_r};
		end else if (sel_en_set || sel_en_clr) begin
			prdata_nxt = {26'h0000000, irq_enable_r}; // R10
		end else if (sel_status) begin
			prdata_nxt = {26'h0000000, event_flags};
		end
	end

	// Captured in setup, held through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= uevr_pkg::READ_ZERO;
			pslverr_r <= 1'h0;
		end else if (setup_phase) begin
			prdata_r  <= pwrite ? uevr_pkg::READ_ZERO : prdata_nxt;
			pslverr_r <= ~sel_any;
		end
	end

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------

	// Zero wait states; error only in access to an unmapped word
	assign pready  = 1'h1;
	assign pslverr = access_phase & pslverr_r;
	assign prdata  = prdata_r;

endmodule : uevr_regs

`default_nettype wire

//--- uevr_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module uevr_regs_checker (
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [11:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [31:0]	prdata,
	input wire logic	pready,
	input wire logic	pslverr,
	input wire logic	cts_n,
	input wire logic	transmit_sent,
	input wire logic	receive_ready,
	input wire logic	error_detected,
	input wire logic	receiver_timeout,
	input wire logic	start_receive_task,
	input wire logic	stop_receive_task,
	input wire logic	irq
);
	// Access phase, committed write and any core event
	wire	acc = psel && penable;
	wire	wr = acc && pwrite;
	wire	ev = transmit_sent | receive_ready |
		     error_detected | receiver_timeout;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_start; start_receive_task |-> !$past(cts_n) && $past(cts_n, 2);
	endproperty
	a_start: assert property (p_start) else $error("start without cts fall");
	property p_stop; stop_receive_task |-> $past(cts_n) && !$past(cts_n, 2);
	endproperty
	a_stop: assert property (p_stop) else $error("stop without cts rise");
	property p_pulse; start_receive_task |=> !start_receive_task;
	endproperty
	a_pulse: assert property (p_pulse) else $error("start pulse too long");
	property p_irq_up;
		$rose(irq) |-> $past(ev || wr) || $changed($past(cts_n));
	endproperty
	a_irq_up: assert property (p_irq_up) else $error("irq rose alone");
	property p_irq_dn; $fell(irq) |-> $past(wr);
	endproperty
	a_irq_dn: assert property (p_irq_dn) else $error("irq fell alone");
	property p_err_acc; pslverr |-> acc;
	endproperty
	a_err_acc: assert property (p_err_acc) else $error("error outside access");
	property p_err_zero; pslverr && !pwrite |-> prdata == 32'h00000000;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("error read not zero");
	property p_mapped; acc && paddr[11:2] == 10'h047 |-> !pslverr;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped word refused");
	// Main scenarios reached
	c_start: cover property (start_receive_task);
	c_stop: cover property (stop_receive_task);
	c_irq: cover property ($rose(irq));
endmodule : uevr_regs_checker
bind uevr_regs uevr_regs_checker u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.cts_n(cts_n), .transmit_sent(transmit_sent), .irq(irq),
	.receive_ready(receive_ready), .error_detected(error_detected),
	.receiver_timeout(receiver_timeout),
	.stop_receive_task(stop_receive_task),
	.start_receive_task(start_receive_task));
`default_nettype wire

//--- uevr_uart_peer.sv
`timescale 1ns/100ps
`default_nettype none
module uevr_uart_peer (
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic [3:0]	ev_req,
	input wire logic	cts_req,
	output logic	transmit_sent,
	output logic	receive_ready,
	output logic	error_detected,
	output logic	receiver_timeout,
	output logic	cts_n
);
	logic [3:0]	ev_r;
	logic	cts_r;
	// One-cycle event pulses, line idles high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_r <= 4'h0;
			cts_r <= 1'h1;
		end else begin
			ev_r <= ev_req;
			cts_r <= cts_req;
		end
	end
	// Pulse fan-out to the core event inputs
	assign {receiver_timeout, error_detected,
	        receive_ready, transmit_sent} = ev_r;
	assign cts_n = cts_r;
endmodule : uevr_uart_peer
`default_nettype wire

//--- uart_event_irq_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module uart_event_irq_regs_tb_top;
	logic	pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic	pwrite = 1'h0, cts_req = 1'h1, pready, pslverr, irq, stx, spx;
	logic	cts_n, ts, rr, er, to;
	logic [11:0]	paddr = 12'h000;
	logic [31:0]	pwdata = 32'h00000000, prdata;
	logic [3:0]	ev_req = 4'h0;
	logic [41:0]	q[$];
	logic [5:0]	fl = 6'h00, en = 6'h00;
	logic [15:0]	lf = 16'hdded;
	logic [11:0]	fo[6] = '{12'h100, 12'h104, 12'h108,
	                          12'h11c, 12'h124, 12'h144};
	int	errors = 0, comparisons = 0, ns = 0, np = 0, xs = 0, xp = 0;
	always #50 pclk = ~pclk;
	uevr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .irq(irq),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n(cts_n),
		.transmit_sent(ts), .receive_ready(rr), .error_detected(er),
		.receiver_timeout(to), .start_receive_task(stx),
		.stop_receive_task(spx));
	uevr_uart_peer peer (.pclk(pclk), .presetn(presetn), .ev_req(ev_req),
		.cts_req(cts_req), .transmit_sent(ts), .receive_ready(rr),
		.error_detected(er), .receiver_timeout(to), .cts_n(cts_n));
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nx
	task automatic chk(input logic [41:0] seen, input logic [41:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("BAD read %h exp %h seen %h", paddr, exp, seen);
		end
	endtask : chk
	// Monitor: task pulse counts, then read results against oldest note
	always @(posedge pclk) begin
		if (stx === 1'h1) ns++;
		if (spx === 1'h1) np++;
		if (psel && penable && pready === 1'h1 && !pwrite)
			chk({ns[3:0], np[3:0], irq, pslverr, prdata},
			    q.pop_front());
	end
	task automatic apb(input logic w, input logic [11:0] a,
	                   input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] d,
	                  input logic e = 1'h0);
		q.push_back({xs[3:0], xp[3:0], |(fl & en), e, d});
		apb(1'h0, a, 32'h00000000);
	endtask : rd
	task automatic pulse(input logic [3:0] m);
		@(posedge pclk);
		ev_req <= m;
		@(posedge pclk);
		ev_req <= 4'h0;
		repeat (2) @(posedge pclk);
		fl |= {m[3:2], m[0], m[1], 2'h0};
	endtask : pulse
	task automatic cts(input logic v);
		@(posedge pclk);
		cts_req <= v;
		repeat (3) @(posedge pclk);
		fl[v] = 1'h1;
	endtask : cts
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		foreach (fo[i]) rd(fo[i], 32'h00000000);
		rd(12'h200, 32'h00000000);
		rd(12'h304, 32'h00000000);
		rd(12'h010, 32'h00000000, 1'h1);
		$display("test reset done");
		wr(12'h304, 32'h00000008);
		en[3] = 1'h1;
		pulse(4'hf);
		for (int i = 2; i < 6; i++) begin
			rd(fo[i], 32'h00000001);
			wr(fo[i], 32'h00000000);
			fl[i] = 1'h0;
			rd(fo[i], 32'h00000000);
		end
		$display("test events done");
		for (int i = 0; i < 6; i++) wr(fo[i], 32'h00000001);
		fl = 6'h3f;
		repeat (6) begin
			lf = nx(lf);
			wr(12'h304, {26'h0, lf[5:0]});
			en |= lf[5:0];
			rd(12'h304, {26'h0, en});
			wr(12'h308, {26'h0, lf[11:6]});
			en &= ~lf[11:6];
			rd(12'h308, {26'h0, en});
		end
		rd(12'h400, 32'h0000003f);
		wr(12'h400, 32'h00000030);
		fl[5:4] = 2'h0;
		rd(12'h400, 32'h0000000f);
		$display("test interrupts done");
		for (int i = 0; i < 2; i++) wr(fo[i], 32'h00000000);
		fl[1:0] = 2'h0;
		wr(12'h200, 32'h00000001);
		cts(1'h0);
		xs++;
		rd(fo[0], 32'h00000001);
		cts(1'h1);
		rd(fo[1], 32'h00000001);
		wr(12'h200, 32'h00000002);
		cts(1'h0);
		cts(1'h1);
		xp++;
		rd(12'h200, 32'h00000002);
		$display("test shortcuts done");
		report_and_stop();
	end
	// Watchdog: the tests need well under a thousand cycles
	initial begin
		#400000;
		errors++;
		report_and_stop();
	end
	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
endmodule : uart_event_irq_regs_tb_top
`default_nettype wire
